//--- rtl/idle_defs.vh
// Constants for the idle-entry gating control: APB offsets, bit positions,
// module indices and reset values. Included by every design file of the block.
`ifndef IDLE_DEFS_VH
`define IDLE_DEFS_VH

// APB byte offsets
`define OFF_ICR      8'h00
`define OFF_IDLE_STATUS_REG     8'h04
`define OFF_MICR     8'h08
`define OFF_PERIPHERAL_IDLE_CONTROL_REG     8'h0c
`define OFF_PDSEL    8'h10
`define OFF_ACK      8'h14
`define OFF_CLKEN    8'h18

// Idle control / status bits, one per clock domain
`define ICR_W        6
`define ICR_CPU      0
`define ICR_MPI      1
`define ICR_INSTRUCTION_CACHE   2
`define ICR_PERI     3
`define ICR_CLK      4
`define ICR_EXTERNAL_MEMORY_INTERFACE     5
`define ICR_RST      6'h00

// Master port idle control bits
`define MICR_W       2
`define MICR_DMA     0
`define MICR_HPI     1
`define MICR_RST     2'h0

// Peripheral idle control bits
`define PERIPHERAL_IDLE_CONTROL_REG_W       11
`define PERIPHERAL_IDLE_CONTROL_REG_TIM     0
`define PERIPHERAL_IDLE_CONTROL_REG_WDT     1
`define PERIPHERAL_IDLE_CONTROL_REG_OST     2
`define PERIPHERAL_IDLE_CONTROL_REG_SP0     3
`define PERIPHERAL_IDLE_CONTROL_REG_GPIO    6
`define PERIPHERAL_IDLE_CONTROL_REG_I2C     7
`define PERIPHERAL_IDLE_CONTROL_REG_UART    8
`define PERIPHERAL_IDLE_CONTROL_REG_PGPIO   9
`define PERIPHERAL_IDLE_CONTROL_REG_EXTERNAL_MEMORY_INTERFACE    10
`define PERIPHERAL_IDLE_CONTROL_REG_RST     11'h000

// Power-down selection bits
`define PD_W         2
`define PD_PLL       0
`define PD_OSC       1
`define PD_RST       2'h0

// Gated module indices
`define NUM_MOD      17
`define M_CPU        0
`define M_CPUREG     1
`define M_DMA        2
`define M_HPI        3
`define M_INSTRUCTION_CACHE     4
`define M_TIM        5
`define M_WDT        6
`define M_OST        7
`define M_SP0        8
`define M_GPIO       11
`define M_I2C        12
`define M_UART       13
`define M_PGPIO      14
`define M_PLLDIV     15
`define M_EXTERNAL_MEMORY_INTERFACE       16

`define NUM_SP       3

`endif

//--- rtl/idle_gate_unit.v
// Per-module idle acknowledge and clock gate flops, one pair per module.
// Assumes request, ready and wake inputs are synchronous to pclk.
`timescale 1ns/1ns
`include "idle_defs.vh"

module idle_gate_unit #(
  parameter N = `NUM_MOD
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [N-1:0] req,
  input  wire [N-1:0] ready,
  input  wire [N-1:0] wake,
  output reg  [N-1:0] ack_ff,
  output reg  [N-1:0] clk_en_ff
);

  reg [N-1:0] nxt_ack;
  reg [N-1:0] nxt_clk_en;

  always @* begin
    // Once idled a module holds, its gated clock cannot change its busy inputs
    nxt_ack    = req & (ack_ff | ready) & ~wake;
    // Gate closes the cycle after the acknowledge
    nxt_clk_en = ~ack_ff;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff    <= {N{1'b0}};
      clk_en_ff <= {N{1'b1}};
    end else begin
      ack_ff    <= nxt_ack;
      clk_en_ff <= nxt_clk_en;
    end
  end

endmodule // idle_gate_unit

//--- rtl/idle_entry_gating_control.v
// Idle-entry gating control: APB idle registers, status capture on the idle
// instruction and per-module entry conditions driving the clock gates.
// Assumes all module activity inputs are synchronous to pclk.
`timescale 1ns/1ns
`include "idle_defs.vh"

module idle_entry_gating_control (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata_ff,
  output reg                  pready_ff,
  output reg                  pslverr_ff,
  input  wire                 idle_exec,
  input  wire                 cpu_wake,
  input  wire                 cpu_pipe_halted,
  input  wire                 dma_busy,
  input  wire                 sp_dma_req,
  input  wire                 instruction_cache_fill_busy,
  input  wire                 instruction_cache_fetch_busy,
  input  wire [`NUM_SP-1:0]   sp_ext_mode,
  input  wire [`NUM_SP-1:0]   sp_busy,
  input  wire [`NUM_SP-1:0]   transmitter_reset_n,
  input  wire [`NUM_SP-1:0]   receiver_reset_n,
  input  wire                 i2c_busy,
  input  wire                 uart_busy,
  output wire [`NUM_MOD-1:0]  clk_en,
  output wire [`NUM_MOD-1:0]  idle_ack,
  output reg                  pll_pwrdn_ff,
  output reg                  osc_pwrdn_ff
);

  // Software-visible state, and the power-down selection latched at idle
  reg [`ICR_W-1:0]    idle_control_reg_ff;
  reg [`ICR_W-1:0]    idle_status_reg_ff;
  reg [`MICR_W-1:0]   master_idle_ctl_ff;
  reg [`PERIPHERAL_IDLE_CONTROL_REG_W-1:0]   peripheral_idle_control_reg_ff;
  reg [`PD_W-1:0]     pd_select_ff;
  reg [`PD_W-1:0]     pd_latched_ff;

  reg [`ICR_W-1:0]    nxt_idle_status_reg;
  reg [`PD_W-1:0]     nxt_pd_latched;
  reg [31:0]          nxt_prdata;
  reg                 nxt_pslverr;
  reg                 nxt_pll_pwrdn;
  reg                 nxt_osc_pwrdn;

  reg [`NUM_MOD-1:0]  mod_req;
  reg [`NUM_MOD-1:0]  mod_ready;
  reg [`NUM_MOD-1:0]  mod_wake;

  wire                setup_ok;
  wire                wr_en;
  wire                cpu_domain_idle_bit;
  wire                peripheral_domain_idle_status;

  integer             i;

  // Serial port entry: {wake, ready}
  function [1:0] sp_cond;
    input ext_mode;
    input busy;
    input transmitter_reset_n_n;
    input receiver_reset_n_n;
    begin
      if (ext_mode)
        sp_cond = {busy, ~busy};
      else
        sp_cond = {transmitter_reset_n_n | receiver_reset_n_n, ~transmitter_reset_n_n & ~receiver_reset_n_n};
    end
  endfunction

  // Known register offsets
  function known_offset;
    input [7:0] addr;
    begin
      case (addr)
        `OFF_ICR, `OFF_IDLE_STATUS_REG, `OFF_MICR, `OFF_PERIPHERAL_IDLE_CONTROL_REG,
        `OFF_PDSEL, `OFF_ACK, `OFF_CLKEN: known_offset = 1'b1;
        default:                          known_offset = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------------
  // APB slave: one wait state, data and error captured with pready
  // ------------------------------------------------------------------
  assign setup_ok = psel & penable & ~pready_ff;
  assign wr_en    = psel & penable & pready_ff & pwrite & known_offset(paddr);

  always @* begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = ~known_offset(paddr);
    case (paddr)
      `OFF_ICR:   nxt_prdata[`ICR_W-1:0]   = idle_control_reg_ff;
      `OFF_IDLE_STATUS_REG:  nxt_prdata[`ICR_W-1:0]   = idle_status_reg_ff;
      `OFF_MICR:  nxt_prdata[`MICR_W-1:0]  = master_idle_ctl_ff;
      `OFF_PERIPHERAL_IDLE_CONTROL_REG:  nxt_prdata[`PERIPHERAL_IDLE_CONTROL_REG_W-1:0]  = peripheral_idle_control_reg_ff;
      `OFF_PDSEL: nxt_prdata[`PD_W-1:0]    = pd_select_ff;
      `OFF_ACK:   nxt_prdata[`NUM_MOD-1:0] = idle_ack;
      `OFF_CLKEN: nxt_prdata[`NUM_MOD-1:0] = clk_en;
      default:    nxt_prdata               = 32'h0000_0000;
    endcase
    // Status registers ignore writes without error
    if (!pwrite)
      nxt_prdata = nxt_prdata;
    else
      nxt_prdata = 32'h0000_0000;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup_ok;
      if (setup_ok) begin
        prdata_ff  <= nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_control_reg_ff            <= `ICR_RST;
      master_idle_ctl_ff             <= `MICR_RST;
      peripheral_idle_control_reg_ff <= `PERIPHERAL_IDLE_CONTROL_REG_RST;
      pd_select_ff                   <= `PD_RST;
    end else if (wr_en) begin
      case (paddr)
        `OFF_ICR:   idle_control_reg_ff            <= pwdata[`ICR_W-1:0];
        `OFF_MICR:  master_idle_ctl_ff             <= pwdata[`MICR_W-1:0];
        `OFF_PERIPHERAL_IDLE_CONTROL_REG:  peripheral_idle_control_reg_ff <= pwdata[`PERIPHERAL_IDLE_CONTROL_REG_W-1:0];
        `OFF_PDSEL: pd_select_ff                   <= pwdata[`PD_W-1:0];
        default:    pd_select_ff                   <= pd_select_ff;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Status capture on the idle instruction
  // ------------------------------------------------------------------
  always @* begin
    nxt_idle_status_reg = idle_status_reg_ff;
    nxt_pd_latched      = pd_latched_ff;
    // CPU wake-up clears the CPU, clock and memory interface status
    if (cpu_wake) begin
      nxt_idle_status_reg[`ICR_CPU]  = 1'b0;
      nxt_idle_status_reg[`ICR_CLK]  = 1'b0;
      nxt_idle_status_reg[`ICR_EXTERNAL_MEMORY_INTERFACE] = 1'b0;
    end
    // Idle instruction wins over a simultaneous wake-up
    if (idle_exec) begin
      nxt_idle_status_reg = idle_control_reg_ff;
      nxt_pd_latched      = pd_select_ff;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_status_reg_ff <= `ICR_RST;
      pd_latched_ff      <= `PD_RST;
    end else begin
      idle_status_reg_ff <= nxt_idle_status_reg;
      pd_latched_ff      <= nxt_pd_latched;
    end
  end

  assign cpu_domain_idle_bit           = idle_status_reg_ff[`ICR_CPU];
  assign peripheral_domain_idle_status = idle_status_reg_ff[`ICR_PERI];

  // ------------------------------------------------------------------
  // Per-module requests and entry conditions
  // ------------------------------------------------------------------
  always @* begin
    mod_req   = {`NUM_MOD{1'b0}};
    mod_ready = {`NUM_MOD{1'b1}};
    mod_wake  = {`NUM_MOD{1'b0}};

    // CPU domain
    mod_req[`M_CPU]      = cpu_domain_idle_bit;
    mod_ready[`M_CPU]    = cpu_pipe_halted;
    mod_req[`M_CPUREG]   = cpu_domain_idle_bit;
    // Interrupt, idle, PLL controllers and selection registers
    mod_ready[`M_CPUREG] = idle_ack[`M_CPU];

    // Master port domain
    mod_req[`M_DMA]   = idle_status_reg_ff[`ICR_MPI] & master_idle_ctl_ff[`MICR_DMA];
    mod_ready[`M_DMA] = ~dma_busy & ~sp_dma_req;
    mod_wake[`M_DMA]  = sp_dma_req;
    mod_req[`M_HPI]   = idle_status_reg_ff[`ICR_MPI] & master_idle_ctl_ff[`MICR_HPI];
    // Host transfers are not protected; software keeps the port quiet
    mod_ready[`M_HPI] = 1'b1;

    // Instruction cache domain
    mod_req[`M_INSTRUCTION_CACHE]   = idle_status_reg_ff[`ICR_INSTRUCTION_CACHE];
    mod_ready[`M_INSTRUCTION_CACHE] = ~instruction_cache_fill_busy & ~instruction_cache_fetch_busy;

    // Peripheral domain: per-module bit and domain status
    mod_req[`M_TIM]   = peripheral_domain_idle_status &
                        peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_TIM];
    mod_req[`M_WDT]   = peripheral_domain_idle_status &
                        peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_WDT];
    mod_req[`M_OST]   = peripheral_domain_idle_status &
                        peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_OST];
    mod_req[`M_GPIO]  = peripheral_domain_idle_status &
                        peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_GPIO];
    mod_req[`M_PGPIO] = peripheral_domain_idle_status &
                        peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_PGPIO];
    mod_req[`M_I2C]   = peripheral_domain_idle_status &
                        peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_I2C];
    mod_req[`M_UART]  = peripheral_domain_idle_status &
                        peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_UART];
    // Timers, watchdog, OS timer and both GPIO blocks keep ready high
    mod_ready[`M_TIM]   = 1'b1;
    mod_ready[`M_WDT]   = 1'b1;
    mod_ready[`M_OST]   = 1'b1;
    mod_ready[`M_GPIO]  = 1'b1;
    mod_ready[`M_PGPIO] = 1'b1;
    mod_ready[`M_I2C]   = ~i2c_busy;
    mod_ready[`M_UART]  = ~uart_busy;

    for (i = 0; i < `NUM_SP; i = i + 1) begin
      mod_req[`M_SP0+i] = peripheral_domain_idle_status &
                          peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_SP0+i];
      {mod_wake[`M_SP0+i], mod_ready[`M_SP0+i]} =
        sp_cond(sp_ext_mode[i], sp_busy[i], transmitter_reset_n[i], receiver_reset_n[i]);
    end

    // Clock generator domain
    mod_req[`M_PLLDIV]   = idle_status_reg_ff[`ICR_CLK];
    mod_ready[`M_PLLDIV] = 1'b1;

    // Memory interface, through its domain bit or its peripheral bit
    mod_req[`M_EXTERNAL_MEMORY_INTERFACE]   = idle_status_reg_ff[`ICR_EXTERNAL_MEMORY_INTERFACE] |
                         (peripheral_domain_idle_status &
                          peripheral_idle_control_reg_ff[`PERIPHERAL_IDLE_CONTROL_REG_EXTERNAL_MEMORY_INTERFACE]);
    mod_ready[`M_EXTERNAL_MEMORY_INTERFACE] = ~dma_busy;
  end

  idle_gate_unit #(
    .N         (`NUM_MOD)
  ) u_gates (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (mod_req),
    .ready     (mod_ready),
    .wake      (mod_wake),
    .ack_ff    (idle_ack),
    .clk_en_ff (clk_en)
  );

  // ------------------------------------------------------------------
  // PLL core and oscillator power-down
  // ------------------------------------------------------------------
  always @* begin
    // Only after the divider has idled, and only if chosen before idling
    nxt_pll_pwrdn = idle_status_reg_ff[`ICR_CLK] & idle_ack[`M_PLLDIV] &
                    pd_latched_ff[`PD_PLL];
    // Oscillator is the last to go, so the PLL is already down
    nxt_osc_pwrdn = nxt_pll_pwrdn & pll_pwrdn_ff &
                    pd_latched_ff[`PD_OSC];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_pwrdn_ff <= 1'b0;
      osc_pwrdn_ff <= 1'b0;
    end else begin
      pll_pwrdn_ff <= nxt_pll_pwrdn;
      osc_pwrdn_ff <= nxt_osc_pwrdn;
    end
  end

endmodule // idle_entry_gating_control

//--- sim/idle_gating_chk.sv
// Checker for the idle-entry gating control: entry conditions and gate order.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
`include "idle_defs.vh"
module idle_gating_chk (
  input logic                pclk,
  input logic                presetn,
  input logic                cpu_pipe_halted,
  input logic                dma_busy,
  input logic                sp_dma_req,
  input logic                instruction_cache_fill_busy,
  input logic                instruction_cache_fetch_busy,
  input logic [`NUM_SP-1:0]  sp_ext_mode,
  input logic [`NUM_SP-1:0]  sp_busy,
  input logic [`NUM_SP-1:0]  transmitter_reset_n,
  input logic [`NUM_SP-1:0]  receiver_reset_n,
  input logic [`NUM_MOD-1:0] clk_en,
  input logic [`NUM_MOD-1:0] idle_ack,
  input logic                pll_pwrdn_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Wake drops the acknowledge first, so the gate never opens under a held ack
  sequence s_reopen;
    !idle_ack[`M_DMA] ##1 clk_en[`M_DMA];
  endsequence
  property p_sp(int j);
    $rose(idle_ack[`M_SP0+j]) |->
      $past(sp_ext_mode[j] ? !sp_busy[j] : !(transmitter_reset_n[j] | receiver_reset_n[j]));
  endproperty
  AST_GATE_AFTER_ACK:
    assert property ((~clk_en & $past(clk_en) & ~$past(idle_ack)) == '0) else $error("gate closed without ack");
  AST_ACK_CLOSES_GATE:
    assert property ((idle_ack & $past(idle_ack) & clk_en) == '0) else $error("ack held but clock runs");
  AST_CPU_HALT:
    assert property ($rose(idle_ack[`M_CPU]) |-> $past(cpu_pipe_halted)) else $error("cpu idled while running");
  AST_CPUREG:
    assert property ($rose(idle_ack[`M_CPUREG]) |-> $past(idle_ack[`M_CPU])) else $error("control idled early");
  AST_DMA_WAIT:
    assert property ($rose(idle_ack[`M_DMA]) |-> $past(!dma_busy && !sp_dma_req)) else $error("dma idled busy");
  AST_DMA_WAKE:
    assert property (idle_ack[`M_DMA] && sp_dma_req |=> s_reopen) else $error("dma did not wake");
  AST_INSTRUCTION_CACHE:
    assert property ($rose(idle_ack[`M_INSTRUCTION_CACHE]) |-> $past(!instruction_cache_fill_busy && !instruction_cache_fetch_busy))
      else $error("cache idled busy");
  AST_SP_EXT:
    assert property (p_sp(0)) else $error("serial port 0 idled early");
  AST_SP_INT:
    assert property (p_sp(1)) else $error("serial port 1 idled early");
  AST_PLL:
    assert property ($rose(pll_pwrdn_ff) |-> $past(idle_ack[`M_PLLDIV])) else $error("pll down early");
  AST_EXTERNAL_MEMORY_INTERFACE:
    assert property ($rose(idle_ack[`M_EXTERNAL_MEMORY_INTERFACE]) |-> $past(!dma_busy)) else $error("memory idled busy");
endmodule // idle_gating_chk

bind idle_entry_gating_control idle_gating_chk u_idle_gating_chk (
  .pclk(pclk), .presetn(presetn), .cpu_pipe_halted(cpu_pipe_halted), .dma_busy(dma_busy),
  .sp_dma_req(sp_dma_req), .instruction_cache_fill_busy(instruction_cache_fill_busy), .instruction_cache_fetch_busy(instruction_cache_fetch_busy),
  .sp_ext_mode(sp_ext_mode), .sp_busy(sp_busy), .transmitter_reset_n(transmitter_reset_n),
  .receiver_reset_n(receiver_reset_n), .clk_en(clk_en), .idle_ack(idle_ack), .pll_pwrdn_ff(pll_pwrdn_ff));

//--- sim/idle_activity_model.sv
// Activity model of the gated modules: each source stays busy for a loaded count.
// Assumes go pulses and len come from the bench on pclk.
`timescale 1ns/1ns
module idle_activity_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic [8:0] go,
  input  logic [7:0] len,
  output logic [8:0] act
);
  logic [7:0] cnt_ff [9];
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 9; i++) begin
      if (!presetn) cnt_ff[i] <= 8'h00;
      else if (go[i]) cnt_ff[i] <= len;
      else if (cnt_ff[i] != 8'h00) cnt_ff[i] <= cnt_ff[i] - 8'h01;
    end
  end
  always_comb for (int i = 0; i < 9; i++) act[i] = cnt_ff[i] != 8'h00;
endmodule // idle_activity_model

//--- sim/idle_entry_gating_control_bench.sv
// Testbench for the idle-entry gating control: APB reads scored against a queue.
// Assumes the activity model stands in for the gated modules.
`timescale 1ns/1ns
`include "idle_defs.vh"
module idle_entry_gating_control_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        idle_exec = 0, cpu_wake = 0, sp_dma_req = 0;
  logic [7:0]  paddr = 0, len = 0;
  logic [31:0] pwdata = 0, r;
  logic [8:0]  go = 0;
  logic [2:0]  ext = 0, xrn = 0, rrn = 0;
  logic [32:0] exp_q[$];
  int          mismatches = 0, num_checks = 0, cyc = 0;
  wire  [31:0] prdata_ff;
  wire  [16:0] clk_en, idle_ack;
  wire  [8:0]  act;
  wire         pready_ff, pslverr_ff, pll_pwrdn_ff, osc_pwrdn_ff;

  always #5 pclk = ~pclk;

  idle_entry_gating_control u_idle_entry_gating_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .idle_exec(idle_exec), .cpu_wake(cpu_wake), .cpu_pipe_halted(~act[0]), .dma_busy(act[1]),
    .sp_dma_req(sp_dma_req), .instruction_cache_fill_busy(act[2]), .instruction_cache_fetch_busy(act[3]), .sp_ext_mode(ext),
    .sp_busy(act[6:4]), .transmitter_reset_n(xrn), .receiver_reset_n(rrn), .i2c_busy(act[7]),
    .uart_busy(act[8]), .clk_en(clk_en), .idle_ack(idle_ack), .pll_pwrdn_ff(pll_pwrdn_ff),
    .osc_pwrdn_ff(osc_pwrdn_ff));
  idle_activity_model u_idle_activity_model (.pclk(pclk), .presetn(presetn), .go(go), .len(len), .act(act));

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Idle cycle before each setup keeps psel from being written twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Ready is sampled at the rising edge, and the request is released at that same edge
    do @(posedge pclk); while (pready_ff !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask
  task automatic ackchk(input logic [16:0] a);
    rd(`OFF_ACK, {16'h0, a});
    rd(`OFF_CLKEN, {16'h0, ~a});
  endtask
  task automatic setup(input logic [5:0] idle_control_reg, input logic [1:0] micr, input logic [10:0] peripheral_idle_control_reg, input logic [1:0] pd);
    apb(1, `OFF_ICR, idle_control_reg);
    apb(1, `OFF_MICR, micr);
    apb(1, `OFF_PERIPHERAL_IDLE_CONTROL_REG, peripheral_idle_control_reg);
    apb(1, `OFF_PDSEL, pd);
    @(posedge pclk);
    idle_exec <= 1;
    @(posedge pclk);
    idle_exec <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic run(input int i);
    @(posedge pclk);
    go[i] <= 1'b1;
    len <= 8'd60 + 8'($urandom_range(30));
    @(posedge pclk);
    go <= '0;
  endtask

  always @(posedge pclk)
    if (psel && penable && !pwrite && pready_ff === 1'b1)
      check({pslverr_ff, prdata_ff}, exp_q.pop_front());

  always @(posedge pclk) begin
    if (++cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(18574));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(`OFF_IDLE_STATUS_REG, 0);
    ackchk(0);
    rd(8'h1c, 33'h1_0000_0000);
    r = $urandom;
    apb(1, `OFF_PERIPHERAL_IDLE_CONTROL_REG, r);
    rd(`OFF_PERIPHERAL_IDLE_CONTROL_REG, {22'h0, r[10:0]});
    apb(1, `OFF_IDLE_STATUS_REG, r);
    rd(`OFF_IDLE_STATUS_REG, 0);
    setup(0, 0, 11'h247, 0);
    ackchk(0);
    setup(8, 0, 11'h247, 0);
    rd(`OFF_IDLE_STATUS_REG, 8);
    ackchk(17'h048e0);
    run(0);
    setup(1, 0, 0, 0);
    ackchk(0);
    repeat (120) @(posedge pclk);
    ackchk(17'h00003);
    @(posedge pclk);
    cpu_wake <= 1;
    @(posedge pclk);
    cpu_wake <= 0;
    ackchk(0);
    run(1);
    setup(2, 3, 0, 0);
    ackchk(17'h00008);
    repeat (120) @(posedge pclk);
    ackchk(17'h0000c);
    @(posedge pclk);
    sp_dma_req <= 1;
    repeat (3) @(posedge pclk);
    ackchk(17'h00008);
    sp_dma_req <= 0;
    repeat (3) @(posedge pclk);
    ackchk(17'h0000c);
    run(2);
    run(3);
    setup(4, 0, 0, 0);
    ackchk(0);
    repeat (120) @(posedge pclk);
    ackchk(17'h00010);
    ext <= 3'b001;
    xrn <= 3'b100;
    run(4);
    run(7);
    setup(8, 0, 11'h1b8, 0);
    ackchk(17'h02200);
    repeat (120) @(posedge pclk);
    ackchk(17'h03300);
    for (int pd = 0; pd < 4; pd += 3) begin
      setup(0, 0, 0, 0);
      run(1);
      setup(6'h30, 0, 0, pd[1:0]);
      ackchk(17'h08000);
      repeat (120) @(posedge pclk);
      ackchk(17'h18000);
      check({31'h0, osc_pwrdn_ff, pll_pwrdn_ff}, 33'(pd));
    end
    setup(0, 0, 0, 0);
    ackchk(0);
    end_of_test();
  end
endmodule // idle_entry_gating_control_bench
